// [rtl/sar_adc_params.svh]
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

// ****************************************************
// register word indices
// ****************************************************
`define ADDR_MODE 10'h000
`define ADDR_PINSEL 10'h001
`define ADDR_RESULT 10'h002
`define ADDR_STATUS 10'h003

// ****************************************************
// reset values
// ****************************************************
`define MODE_RESET 8'h01
`define PINSEL_RESET 8'h00

// ****************************************************
// mode register fields
// ****************************************************
`define MODE_RUN_BIT 7
`define MODE_TRIG_BIT 6
`define MODE_TIME_HI 5
`define MODE_TIME_LO 4
`define MODE_CH_HI 3
`define MODE_CH_LO 1
`define MODE_FIXED_BIT 0

// ****************************************************
// status register fields
// ****************************************************
`define STAT_DONE_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_STATE_LO 2

// ****************************************************
// conversion timing, in system clocks
// ****************************************************
`define CONV_CLKS_CODE0 160
`define CONV_CLKS_CODE1 80
`define CONV_CLKS_CODE2 200
`define STEPS_PER_CONV 10
`define SAMPLE_STEPS 2
`define MSB_SEED 8'h80
`define MSB_INDEX 3'h7

`endif

// [rtl/sar_adc_pkg.sv]
package sar_adc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONVERT = 2'b11
    } conv_state_t;

endpackage

// [rtl/sar_adc_sequencer.sv]
// Function
// - sample the input for a fixed period, then hold until conversion ends
// - comparison starts with top bit set and tap at half reference
// - top bit stays one when input at or above half reference, else cleared
// - next bit set, tap chosen from bits already decided
// - trial bit kept when input at or above tap, cleared when below
// - one bit per step from top bit down to bit zero
// - after eight bits copy value to result and raise done request
// - convert repeatedly while run bit is one, stop when cleared
// - any mode write aborts the sequence, run bit set restarts it
// - result register has no reset value
// - code is input over reference times 256, rounded to nearest
// - trigger and run set: wait for start pulse, convert chosen channel
// - hardware start: one conversion per pulse, then wait again
// - hardware start rewrite with run set: abandon, await fresh pulse
// - mode write with run cleared halts at once, no result stored
// - software start: convert at once and back to back
// - software start rewrite with run set restarts with new settings
// - mode writes leave the done request flag unchanged
// - converter runs on the system clock only, halts when it stops
// - three-bit channel code in mode bits 3 to 1 picks input 0 to 7
// - time code gives 160, 80 or 200 clocks, code 11 prohibited
// - mode register resets to 01H, bit zero always reads one
// - pin select register resets to zero, all pins are ports
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_params.svh"

module sar_adc_sequencer (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic comparator_ge,
    output logic sample_hold,
    output logic [7:0] tap_code,
    output logic [2:0] channel_select,
    output logic [7:0] analog_pin_enable,
    // events and state
    input wire logic external_start_pulse,
    output logic conversion_done_irq,
    output sar_adc_pkg::conv_state_t conv_state
);
    import sar_adc_pkg::*;

    // ****************************************************
    // declarations
    // ****************************************************
    logic [7:0] converter_mode_reg;
    logic [7:0] analog_pin_select_reg;
    logic [7:0] approximation_reg;
    logic [7:0] result_holding_reg;
    logic done_request_flag;
    conv_state_t state;
    logic [2:0] bit_idx;
    logic [7:0] step_cnt;
    logic [7:0] step_len;
    logic [7:0] last_cnt;
    logic step_end;
    logic conv_last;
    logic access;
    logic mode_wr;
    logic pinsel_wr;
    logic status_wr;
    logic addr_hit;
    logic run_bit;
    logic trigger_source_bit;
    logic [9:0] word_addr;

    assign word_addr = paddr[11:2];
    assign run_bit = converter_mode_reg[`MODE_RUN_BIT];
    assign trigger_source_bit = converter_mode_reg[`MODE_TRIG_BIT];

    // ****************************************************
    // apb decode
    // ****************************************************
    always_comb begin
        unique case (word_addr)
            `ADDR_MODE,
            `ADDR_PINSEL,
            `ADDR_RESULT,
            `ADDR_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // frozen clock stalls the bus too
    assign pready = clk_en;
    assign access = psel & penable & clk_en;
    assign pslverr = psel & penable & ~addr_hit;
    assign mode_wr = access & pwrite & (word_addr == `ADDR_MODE);
    assign pinsel_wr = access & pwrite & (word_addr == `ADDR_PINSEL);
    assign status_wr = access & pwrite & (word_addr == `ADDR_STATUS);

    // read data captured in the setup cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable) begin
            unique case (word_addr)
                `ADDR_MODE: prdata <= {24'h000000, converter_mode_reg};
                `ADDR_PINSEL: prdata <= {24'h000000, analog_pin_select_reg};
                `ADDR_RESULT: prdata <= {24'h000000, result_holding_reg};
                `ADDR_STATUS: begin
                    prdata <= 32'h00000000;
                    prdata[`STAT_DONE_BIT] <= done_request_flag;
                    prdata[`STAT_BUSY_BIT] <= state[1];
                    prdata[`STAT_STATE_LO +: 2] <= state;
                end
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************
    // control registers
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            converter_mode_reg <= `MODE_RESET;
        end else if (clk_en && mode_wr) begin
            converter_mode_reg <= pwdata[7:0];
            converter_mode_reg[`MODE_FIXED_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            analog_pin_select_reg <= `PINSEL_RESET;
        end else if (clk_en && pinsel_wr) begin
            analog_pin_select_reg <= pwdata[7:0];
        end
    end

    assign analog_pin_enable = analog_pin_select_reg;
    assign channel_select =
        converter_mode_reg[`MODE_CH_HI:`MODE_CH_LO];

    // ****************************************************
    // step timing
    // ****************************************************
    always_comb begin
        unique case (converter_mode_reg[`MODE_TIME_HI:`MODE_TIME_LO])
            2'b00: step_len = 8'(`CONV_CLKS_CODE0 / `STEPS_PER_CONV);
            2'b01: step_len = 8'(`CONV_CLKS_CODE1 / `STEPS_PER_CONV);
            // prohibited code runs at the slowest rate
            2'b10,
            2'b11: step_len = 8'(`CONV_CLKS_CODE2 / `STEPS_PER_CONV);
        endcase
    end

    always_comb begin
        last_cnt = 8'h00;
        if (state == ST_SAMPLE) begin
            last_cnt = 8'(step_len * `SAMPLE_STEPS - 1);
        end else begin
            last_cnt = 8'(step_len - 8'h01);
        end
    end

    assign step_end = (state == ST_SAMPLE || state == ST_CONVERT)
        && (step_cnt == last_cnt);
    assign conv_last = (state == ST_CONVERT) && step_end
        && (bit_idx == 3'h0) && !mode_wr;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_cnt <= 8'h00;
        end else if (clk_en) begin
            if (mode_wr || step_end || !state[1]) begin
                step_cnt <= 8'h00;
            end else begin
                step_cnt <= step_cnt + 8'h01;
            end
        end
    end

    // ****************************************************
    // sequencer
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            if (mode_wr) begin
                if (!pwdata[`MODE_RUN_BIT]) begin
                    state <= ST_IDLE;
                end else if (pwdata[`MODE_TRIG_BIT]) begin
                    state <= ST_WAIT;
                end else begin
                    state <= ST_SAMPLE;
                end
            end else begin
                unique case (state)
                    ST_IDLE: state <= ST_IDLE;
                    ST_WAIT: begin
                        if (external_start_pulse) begin
                            state <= ST_SAMPLE;
                        end
                    end
                    ST_SAMPLE: begin
                        if (step_end) begin
                            state <= ST_CONVERT;
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_last) begin
                            if (trigger_source_bit) begin
                                state <= ST_WAIT;
                            end else begin
                                state <= ST_SAMPLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign conv_state = state;
    assign sample_hold = (state == ST_CONVERT);

    // ****************************************************
    // approximation
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            approximation_reg <= 8'h00;
            bit_idx <= 3'h0;
        end else if (clk_en && !mode_wr) begin
            if (state == ST_SAMPLE && step_end) begin
                approximation_reg <= `MSB_SEED;
                bit_idx <= `MSB_INDEX;
            end else if (state == ST_CONVERT && step_end) begin
                approximation_reg[bit_idx] <= comparator_ge;
                if (bit_idx != 3'h0) begin
                    approximation_reg[3'(bit_idx - 3'h1)] <= 1'b1;
                    bit_idx <= 3'(bit_idx - 3'h1);
                end
            end
        end
    end

    // trial value drives the tap, half-step offset lives in the string
    assign tap_code = approximation_reg;

    // ****************************************************
    // result and done request
    // ****************************************************
    always_ff @(posedge clk) begin
        if (clk_en && conv_last) begin
            result_holding_reg <= {approximation_reg[7:1], comparator_ge};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conversion_done_irq <= 1'b0;
        end else if (clk_en) begin
            conversion_done_irq <= conv_last;
        end
    end

    // set wins over clear; mode writes never touch it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_request_flag <= 1'b0;
        end else if (clk_en) begin
            if (conv_last) begin
                done_request_flag <= 1'b1;
            end else if (status_wr && pwdata[`STAT_DONE_BIT]) begin
                done_request_flag <= 1'b0;
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    property p_hold_after_sample;
        @(posedge clk) disable iff (!resetn)
        $rose(sample_hold) |-> $past(state) == ST_SAMPLE;
    endproperty
    a_hold_after_sample: assert property (p_hold_after_sample)
        else $error("hold entered without sampling");

    property p_msb_seed;
        @(posedge clk) disable iff (!resetn)
        (clk_en && state == ST_SAMPLE && step_end && !mode_wr)
        |=> state == ST_CONVERT && approximation_reg == 8'h80
        && bit_idx == 3'h7;
    endproperty
    a_msb_seed: assert property (p_msb_seed)
        else $error("comparison did not start at top bit");

    property p_bit_decide;
        @(posedge clk) disable iff (!resetn)
        (clk_en && state == ST_CONVERT && step_end && !mode_wr
        && bit_idx != 3'h0)
        |=> approximation_reg[$past(bit_idx)] == $past(comparator_ge)
        && approximation_reg[bit_idx] && bit_idx == $past(bit_idx) - 3'h1;
    endproperty
    a_bit_decide: assert property (p_bit_decide)
        else $error("trial bit decided wrongly");

    property p_result_store;
        @(posedge clk) disable iff (!resetn)
        (clk_en && conv_last) |=> conversion_done_irq && done_request_flag
        && result_holding_reg[0] == $past(comparator_ge)
        && result_holding_reg[7:1] == $past(approximation_reg[7:1]);
    endproperty
    a_result_store: assert property (p_result_store)
        else $error("result or done request missing");

    property p_hw_one_shot;
        @(posedge clk) disable iff (!resetn)
        (clk_en && conv_last && trigger_source_bit) |=> state == ST_WAIT;
    endproperty
    a_hw_one_shot: assert property (p_hw_one_shot)
        else $error("hardware start did not return to waiting");

    property p_sw_repeat;
        @(posedge clk) disable iff (!resetn)
        (clk_en && conv_last && !trigger_source_bit)
        |=> state == ST_SAMPLE && step_cnt == 8'h00;
    endproperty
    a_sw_repeat: assert property (p_sw_repeat)
        else $error("software start did not restart");

    property p_stop_now;
        @(posedge clk) disable iff (!resetn)
        (mode_wr && !pwdata[7]) |=> state == ST_IDLE && !conversion_done_irq;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("run bit cleared but conversion went on");

    property p_flag_kept;
        @(posedge clk) disable iff (!resetn)
        (mode_wr && done_request_flag) |=> done_request_flag;
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("mode write changed the done flag");

    property p_pulse_ignored;
        @(posedge clk) disable iff (!resetn)
        (clk_en && state[1] && external_start_pulse && !mode_wr && !step_end)
        |=> state == $past(state) && step_cnt == $past(step_cnt) + 8'h01;
    endproperty
    a_pulse_ignored: assert property (p_pulse_ignored)
        else $error("start pulse disturbed a running conversion");

    property p_rewrite_hw;
        @(posedge clk) disable iff (!resetn)
        (mode_wr && pwdata[7] && pwdata[6]) |=> state == ST_WAIT;
    endproperty
    a_rewrite_hw: assert property (p_rewrite_hw)
        else $error("hardware rewrite did not wait for a pulse");

    property p_bit0_one;
        @(posedge clk) disable iff (!resetn)
        mode_wr |=> converter_mode_reg[0]
        && converter_mode_reg[7:1] == $past(pwdata[7:1]);
    endproperty
    a_bit0_one: assert property (p_bit0_one)
        else $error("mode register bit zero not one");

endmodule

`default_nettype wire

// [testbench/afe_model.sv]
`timescale 1ns/1ns
`default_nettype none
module afe_model (
    // timing
    input wire logic clk,
    // front end
    input wire logic sample_hold,
    input wire logic [7:0] tap_code,
    input wire logic [2:0] channel_select,
    input wire logic [8:0] vin [8],
    output logic comparator_ge
);
    // ********
    // sample, hold and compare
    // ********
    logic [8:0] held;

    // input kept in half steps
    always_ff @(posedge clk) begin
        if (!sample_hold) begin
            held <= vin[channel_select];
        end
    end

    // tap sits half a step low, so codes round to nearest
    assign comparator_ge = ({1'b0, held} + 10'h001) >= {1'b0, tap_code, 1'b0};
endmodule
`default_nettype wire

// [testbench/tb_sar_adc_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_sequencer;
    import sar_adc_pkg::*;
    // ********
    // signals and instances
    // ********
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, comparator_ge, sample_hold, conversion_done_irq;
    logic [7:0] tap_code, analog_pin_enable;
    logic [2:0] channel_select;
    logic external_start_pulse = 1'b0;
    conv_state_t conv_state;
    logic [8:0] vin [8] = '{9'h000, 9'h001, 9'h0C9, 9'h12C,
                            9'h100, 9'h04D, 9'h1FF, 9'h0FF};
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    sar_adc_sequencer u_sar_adc_sequencer (.clk(clk), .resetn(resetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_ge(comparator_ge),
        .sample_hold(sample_hold), .tap_code(tap_code),
        .channel_select(channel_select),
        .analog_pin_enable(analog_pin_enable),
        .external_start_pulse(external_start_pulse),
        .conversion_done_irq(conversion_done_irq), .conv_state(conv_state));

    afe_model u_afe_model (.clk(clk), .sample_hold(sample_hold),
        .tap_code(tap_code), .channel_select(channel_select), .vin(vin),
        .comparator_ge(comparator_ge));

    always #10 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            final_report;
        end
    end

    // ********
    // helpers
    // ********
    function automatic logic [7:0] exp_code(input int ch);
        logic [9:0] t;
        t = {1'b0, vin[ch]} + 10'h001;
        return t[9] ? 8'hFF : t[8:1];
    endfunction

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            $display("Error at %0t: %s", $time, msg);
            n_fail++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse;
        @(posedge clk);
        external_start_pulse <= 1'b1;
        @(posedge clk);
        external_start_pulse <= 1'b0;
    endtask

    task automatic quiet(input int c);
        int hits;
        hits = 0;
        repeat (c) begin
            @(posedge clk);
            #1;
            if (conversion_done_irq === 1'b1) hits++;
        end
        check(hits == 0, "unexpected completion");
    endtask

    // skip: cycles already spent since the conversion began
    task automatic wait_conv(input int s, input int skip, input int ch);
        int n;
        logic [7:0] e;
        n = 0;
        e = exp_code(ch);
        while (n < 2000 && conversion_done_irq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (skip == 0 && n == 1)
                check(sample_hold === 1'b0, "not sampling");
            if (skip == 0 && n == 2 * s + 1)
                check(sample_hold === 1'b1 && tap_code === 8'h80, "msb");
            if (skip == 0 && n == 3 * s + 1)
                check(tap_code[7:6] === {e[7], 1'b1}, "second tap");
        end
        check(n == 10 * s - skip, "conversion time");
        check(channel_select === ch[2:0], "channel");
        apb(1'b0, 12'h008, 32'h0);
        check(rd === {24'h0, e}, "result");
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check(rd === 32'h01, "mode reset");
        apb(1'b1, 12'h000, 32'h2E);
        apb(1'b0, 12'h000, 32'h0);
        check(rd === 32'h2F, "mode fixed bit");
        check(channel_select === 3'h7, "channel code");
        apb(1'b0, 12'h004, 32'h0);
        check(rd === 32'h00, "pin select reset");
        apb(1'b1, 12'h004, 32'hA5);
        apb(1'b0, 12'h004, 32'h0);
        check(rd === 32'hA5 && analog_pin_enable === 8'hA5, "pins");
        apb(1'b1, 12'h010, 32'hFF);
        check(err === 1'b1, "unmapped write");
        apb(1'b0, 12'h010, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped read");
    endtask

    task automatic t_soft;
        int s [3] = '{16, 8, 20};
        apb(1'b1, 12'h004, 32'hFF);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, 12'h000, {24'h0, 2'b10, c[1:0], c[2:0] + 3'h2, 1'b1});
            wait_conv(s[c], 0, c + 2);
            wait_conv(s[c], 3, c + 2);
        end
        apb(1'b1, 12'h000, 32'h01);
        quiet(300);
        check(conv_state === ST_IDLE, "stopped");
    endtask

    task automatic t_rewrite;
        apb(1'b1, 12'h00C, 32'h01);
        apb(1'b1, 12'h000, 32'h95);
        quiet(40);
        apb(1'b1, 12'h000, 32'h9B);
        wait_conv(8, 0, 5);
        apb(1'b1, 12'h000, 32'h01);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd[0] === 1'b1, "flag kept");
        check(rd[3:2] === ST_IDLE, "halted");
        quiet(200);
        apb(1'b1, 12'h00C, 32'h01);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd[0] === 1'b0, "flag cleared");
    endtask

    task automatic t_hw;
        apb(1'b1, 12'h000, 32'hDD);
        quiet(100);
        check(conv_state === ST_WAIT, "waiting");
        pulse;
        wait_conv(8, 0, 6);
        quiet(100);
        check(conv_state === ST_WAIT, "back to wait");
        pulse;
        quiet(20);
        pulse;
        wait_conv(8, 22, 6);
        pulse;
        quiet(30);
        apb(1'b1, 12'h000, 32'hDD);
        quiet(100);
        check(conv_state === ST_WAIT, "abandoned");
        pulse;
        wait_conv(8, 0, 6);
        apb(1'b1, 12'h000, 32'h01);
    endtask

    // frozen clock stretches the conversion by the frozen cycles
    task automatic t_freeze;
        apb(1'b1, 12'h00C, 32'h01);
        apb(1'b1, 12'h000, 32'h95);
        clk_en <= 1'b0;
        quiet(20);
        check(conv_state === ST_SAMPLE && pready === 1'b0, "frozen");
        @(posedge clk);
        clk_en <= 1'b1;
        wait_conv(8, 0, 2);
        apb(1'b1, 12'h000, 32'h01);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_soft;
        t_rewrite;
        t_hw;
        t_freeze;
        final_report;
    end
endmodule
`default_nettype wire
